// [common/pirl_pkg.sv]
// Operation
// R01: Frame-class field bits 3-2, reset 00, selects which frames are counted and limited.
// R02: Gap flag bit 1 adds 12 bytes per frame to ingress and egress accounting.
// R03: Preamble flag bit 0 adds 8 bytes per frame to ingress and egress accounting.
// R04: Software keeps bits 7-4 of the frame-class register at zero.
// R05: Priority 1 ingress rate code sits in bits 7-4 of the low rate register.
// R06: Priority 0 ingress rate code sits in bits 3-0 of the low rate register.
// R07: Rate code 0000 means no limiting; this is the reset state.
// R08: Codes 0001-1111 shape to 64K..32M, then 48, 64, 72, 80, 88 Mbps.
// R09: At 10 megabit port speed, codes above 10 Mbps act as 0000.
// R10: Priority 3 and 2 codes sit in bits 7-4 and 3-0 of the high rate register.
// R11: Bytes per priority are counted per window; over-budget frames are dropped until renewal.
package pirl_pkg;

	localparam int NUM_PORTS = 3;
	localparam int NUM_PRIO = 4;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_P1_CFG = 6'h15;
	localparam logic [5:0] IDX_P1_RLO = 6'h16;
	localparam logic [5:0] IDX_P1_RHI = 6'h17;
	localparam logic [5:0] IDX_P2_CFG = 6'h25;
	localparam logic [5:0] IDX_P2_RLO = 6'h26;
	localparam logic [5:0] IDX_P2_RHI = 6'h27;
	localparam logic [5:0] IDX_P3_CFG = 6'h35;
	localparam logic [5:0] IDX_P3_RLO = 6'h36;
	localparam logic [5:0] IDX_P3_RHI = 6'h37;
	localparam logic [5:0] IDX_DROP_P1 = 6'h3D;
	localparam logic [5:0] IDX_DROP_P2 = 6'h3E;
	localparam logic [5:0] IDX_DROP_P3 = 6'h3F;

	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h00;

	// Field positions
	localparam int CFG_MODE_LSB = 2;
	localparam int CFG_GAP_BIT = 1;
	localparam int CFG_PRE_BIT = 0;
	localparam int RATE_HI_LSB = 4;
	localparam int RATE_LO_LSB = 0;

	localparam logic [1:0] MODE_ALL = 2'h0;
	localparam logic [1:0] MODE_BMF = 2'h1;
	localparam logic [1:0] MODE_BM = 2'h2;
	localparam logic [1:0] MODE_B = 2'h3;

	localparam logic [3:0] CODE_OFF = 4'h0;
	// Highest code whose rate fits a 10 megabit port
	localparam logic [3:0] CODE_MAX_10M = 4'h8;

	localparam logic [11:0] GAP_BYTES = 12'h00C;
	localparam logic [11:0] PRE_BYTES = 12'h008;

	// Accounting window
	localparam int CLK_KHZ = 10000;
	localparam int WINDOW_US = 1000;
	localparam int WINDOW_CYCLES = (WINDOW_US * CLK_KHZ) / 1000;

	typedef struct packed {
		logic [1:0] port;
		logic [1:0] prio;
		logic is_bcast;
		logic is_mcast;
		logic is_flood;
		logic [10:0] len;
	} pirl_frame_t;

	typedef struct packed {
		logic [1:0] port;
		logic [1:0] prio;
		logic pass;
		logic counted;
	} pirl_verdict_t;

	function automatic int rate_kbps(input logic [3:0] code);
		case (code)
			4'h1: rate_kbps = 64;
			4'h2: rate_kbps = 128;
			4'h3: rate_kbps = 256;
			4'h4: rate_kbps = 512;
			4'h5: rate_kbps = 1000;
			4'h6: rate_kbps = 2000;
			4'h7: rate_kbps = 4000;
			4'h8: rate_kbps = 8000;
			4'h9: rate_kbps = 16000;
			4'hA: rate_kbps = 32000;
			4'hB: rate_kbps = 48000;
			4'hC: rate_kbps = 64000;
			4'hD: rate_kbps = 72000;
			4'hE: rate_kbps = 80000;
			4'hF: rate_kbps = 88000;
			default: rate_kbps = 0;
		endcase
	endfunction

endpackage

// [rtl/pirl_bucket.sv]
`timescale 1ns/1ns
module pirl_bucket #(
	parameter int BYTE_W = 24,
	parameter int WIN_US = pirl_pkg::WINDOW_US
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic window_tick,
	input wire logic [3:0] code,
	input wire logic req,
	input wire logic [BYTE_W-1:0] bytes,
	output logic allow
);
	logic [BYTE_W-1:0] used_q;
	logic [BYTE_W-1:0] used_d;
	logic [BYTE_W-1:0] budget;
	logic [BYTE_W:0] sum;

	// Bytes allowed per window: kbps * us / 8000
	always_comb begin
		budget = BYTE_W'((64'(pirl_pkg::rate_kbps(code)) * 64'(WIN_US)) / 64'd8000); // [R08]
	end

	always_comb begin
		sum = {1'b0, used_q} + {1'b0, bytes};
		allow = (code == pirl_pkg::CODE_OFF) || (sum <= {1'b0, budget}); // [R07] [R11]
	end

	always_comb begin
		used_d = window_tick ? '0 : used_q; // [R11]
		if (req && allow && code != pirl_pkg::CODE_OFF) begin
			// Frame landing on the renewal edge charges the fresh window
			used_d = window_tick ? bytes : sum[BYTE_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			used_q <= '0;
		end else begin
			used_q <= used_d;
		end
	end
endmodule

// [rtl/pirl_top.sv]
`timescale 1ns/1ns
module pirl_top #(
	parameter int WINDOW_CYCLES = pirl_pkg::WINDOW_CYCLES,
	parameter int BYTE_W = 24
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_valid,
	input wire pirl_pkg::pirl_frame_t frame,
	input wire logic [2:0] port_speed10,
	output logic verdict_valid,
	output pirl_pkg::pirl_verdict_t verdict,
	output logic [2:0] gap_bytes_include,
	output logic [2:0] preamble_include
);
	////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [7:0] cfg_q [3];
	logic [7:0] rlo_q [3];
	logic [7:0] rhi_q [3];
	logic [7:0] drop_q [3];

	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	logic [5:0] idx;
	logic hit;
	logic [1:0] hit_port;
	logic [1:0] hit_kind;
	logic [7:0] rd_val;
	logic wr_take;

	localparam logic [1:0] KIND_CFG = 2'h0;
	localparam logic [1:0] KIND_RLO = 2'h1;
	localparam logic [1:0] KIND_RHI = 2'h2;
	localparam logic [1:0] KIND_DROP = 2'h3;

	assign idx = paddr[7:2];

	////////////////////////////////////////////////////////////////////////
	// Address decode
	always_comb begin
		hit = 1'b1;
		hit_port = 2'h0;
		hit_kind = KIND_CFG;
		if (paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end else if (idx == pirl_pkg::IDX_P1_CFG) begin
			hit_port = 2'h0;
			hit_kind = KIND_CFG;
		end else if (idx == pirl_pkg::IDX_P1_RLO) begin
			hit_port = 2'h0;
			hit_kind = KIND_RLO;
		end else if (idx == pirl_pkg::IDX_P1_RHI) begin
			hit_port = 2'h0;
			hit_kind = KIND_RHI;
		end else if (idx == pirl_pkg::IDX_P2_CFG) begin
			hit_port = 2'h1;
			hit_kind = KIND_CFG;
		end else if (idx == pirl_pkg::IDX_P2_RLO) begin
			hit_port = 2'h1;
			hit_kind = KIND_RLO;
		end else if (idx == pirl_pkg::IDX_P2_RHI) begin
			hit_port = 2'h1;
			hit_kind = KIND_RHI;
		end else if (idx == pirl_pkg::IDX_P3_CFG) begin
			hit_port = 2'h2;
			hit_kind = KIND_CFG;
		end else if (idx == pirl_pkg::IDX_P3_RLO) begin
			hit_port = 2'h2;
			hit_kind = KIND_RLO;
		end else if (idx == pirl_pkg::IDX_P3_RHI) begin
			hit_port = 2'h2;
			hit_kind = KIND_RHI;
		end else if (idx == pirl_pkg::IDX_DROP_P1) begin
			hit_port = 2'h0;
			hit_kind = KIND_DROP;
		end else if (idx == pirl_pkg::IDX_DROP_P2) begin
			hit_port = 2'h1;
			hit_kind = KIND_DROP;
		end else if (idx == pirl_pkg::IDX_DROP_P3) begin
			hit_port = 2'h2;
			hit_kind = KIND_DROP;
		end else begin
			hit = 1'b0;
		end
	end

	always_comb begin
		case (hit_kind)
			KIND_CFG: rd_val = cfg_q[hit_port];
			KIND_RLO: rd_val = rlo_q[hit_port];
			KIND_RHI: rd_val = rhi_q[hit_port];
			default: rd_val = drop_q[hit_port];
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// APB handshake: answer is prepared in the setup cycle so that
	// every bus output comes from a flop; one access cycle per transfer
	assign wr_take = psel && penable && pready_q && pwrite && hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready_q <= 1'b1;
			pslverr_q <= !hit;
			prdata_q <= (!pwrite && hit) ? {24'h00_0000, rd_val} : 32'h0000_0000;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < pirl_pkg::NUM_PORTS; p++) begin
				cfg_q[p] <= pirl_pkg::CFG_RESET; // [R01] [R02] [R03]
				rlo_q[p] <= pirl_pkg::RATE_RESET; // [R07]
				rhi_q[p] <= pirl_pkg::RATE_RESET; // [R07]
			end
		end else if (wr_take) begin
			// Upper config bits are stored as written; the limiter never looks at them
			case (hit_kind)
				KIND_CFG: cfg_q[hit_port] <= pwdata[7:0];
				KIND_RLO: rlo_q[hit_port] <= pwdata[7:0]; // [R05] [R06]
				KIND_RHI: rhi_q[hit_port] <= pwdata[7:0]; // [R10]
				default: ;
			endcase
		end
	end

	always_comb begin
		for (int p = 0; p < pirl_pkg::NUM_PORTS; p++) begin
			gap_bytes_include[p] = cfg_q[p][pirl_pkg::CFG_GAP_BIT]; // [R02]
			preamble_include[p] = cfg_q[p][pirl_pkg::CFG_PRE_BIT]; // [R03]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Window divider
	logic [31:0] win_cnt_q;
	logic window_tick;

	assign window_tick = (win_cnt_q == 32'(WINDOW_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_cnt_q <= 32'h0000_0000;
		end else if (window_tick) begin
			win_cnt_q <= 32'h0000_0000;
		end else begin
			win_cnt_q <= win_cnt_q + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame classification and byte count
	logic [1:0] fport;
	logic [1:0] mode;
	logic qualify;
	logic [11:0] fbytes;
	localparam int NUM_B = pirl_pkg::NUM_PORTS * pirl_pkg::NUM_PRIO;
	logic [BYTE_W-1:0] fbytes_w;
	logic [NUM_B-1:0] allow_vec;
	logic [NUM_B-1:0] req_vec;

	// Port numbers beyond the last port fold onto it
	assign fport = (frame.port > 2'h2) ? 2'h2 : frame.port;
	assign mode = cfg_q[fport][pirl_pkg::CFG_MODE_LSB +: 2];

	always_comb begin
		case (mode) // [R01]
			pirl_pkg::MODE_ALL: qualify = 1'b1;
			pirl_pkg::MODE_BMF: qualify = frame.is_bcast || frame.is_mcast || frame.is_flood;
			pirl_pkg::MODE_BM: qualify = frame.is_bcast || frame.is_mcast;
			default: qualify = frame.is_bcast;
		endcase
	end

	always_comb begin
		fbytes = {1'b0, frame.len};
		if (cfg_q[fport][pirl_pkg::CFG_GAP_BIT]) begin
			fbytes = fbytes + pirl_pkg::GAP_BYTES; // [R02]
		end
		if (cfg_q[fport][pirl_pkg::CFG_PRE_BIT]) begin
			fbytes = fbytes + pirl_pkg::PRE_BYTES; // [R03]
		end
	end

	assign fbytes_w = BYTE_W'(fbytes);

	////////////////////////////////////////////////////////////////////////
	// One byte bucket per port and priority
	genvar gp;
	genvar gq;
	generate
		for (gp = 0; gp < pirl_pkg::NUM_PORTS; gp++) begin : g_port
			for (gq = 0; gq < pirl_pkg::NUM_PRIO; gq++) begin : g_prio
				logic [3:0] raw_code;
				logic [3:0] eff_code;
				if (gq == 0) begin : g_c0
					assign raw_code = rlo_q[gp][pirl_pkg::RATE_LO_LSB +: 4]; // [R06]
				end else if (gq == 1) begin : g_c1
					assign raw_code = rlo_q[gp][pirl_pkg::RATE_HI_LSB +: 4]; // [R05]
				end else if (gq == 2) begin : g_c2
					assign raw_code = rhi_q[gp][pirl_pkg::RATE_LO_LSB +: 4]; // [R10]
				end else begin : g_c3
					assign raw_code = rhi_q[gp][pirl_pkg::RATE_HI_LSB +: 4]; // [R10]
				end
				// Rates above the line speed of a 10 megabit port mean unlimited
				assign eff_code = (port_speed10[gp] && raw_code > pirl_pkg::CODE_MAX_10M) ?
					pirl_pkg::CODE_OFF : raw_code; // [R09]
				assign req_vec[gp*4+gq] = frame_valid && qualify &&
					fport == 2'(gp) && frame.prio == 2'(gq); // [R11]
				pirl_bucket #(
					.BYTE_W(BYTE_W)
				) u_bucket (
					.pclk(pclk),
					.presetn(presetn),
					.window_tick(window_tick),
					.code(eff_code),
					.req(req_vec[gp*4+gq]),
					.bytes(fbytes_w),
					.allow(allow_vec[gp*4+gq])
				);
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Verdict, one cycle after the frame is offered
	logic pass_now;
	assign pass_now = !qualify || allow_vec[{fport, frame.prio}]; // [R11]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			verdict_valid <= 1'b0;
			verdict <= '0;
		end else begin
			verdict_valid <= frame_valid;
			if (frame_valid) begin
				verdict.port <= fport;
				verdict.prio <= frame.prio;
				verdict.pass <= pass_now;
				verdict.counted <= qualify; // [R01]
			end
		end
	end

	// Drop counters saturate; a write clears, but a drop in the same cycle still counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < pirl_pkg::NUM_PORTS; p++) begin
				drop_q[p] <= 8'h00;
			end
		end else begin
			for (int p = 0; p < pirl_pkg::NUM_PORTS; p++) begin
				if (frame_valid && !pass_now && fport == 2'(p)) begin
					if (wr_take && hit_kind == KIND_DROP && hit_port == 2'(p)) begin
						drop_q[p] <= 8'h01;
					end else if (drop_q[p] != 8'hFF) begin
						drop_q[p] <= drop_q[p] + 8'h01;
					end
				end else if (wr_take && hit_kind == KIND_DROP && hit_port == 2'(p)) begin
					drop_q[p] <= 8'h00;
				end
			end
		end
	end
endmodule

// [test/pirl_frame_src.sv]
`timescale 1ns/1ns
module pirl_frame_src (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire pirl_pkg::pirl_frame_t f_in,
	output logic frame_valid,
	output pirl_pkg::pirl_frame_t frame
);
	// Idle cycles scramble the fields so stale ones are never trusted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_valid <= 1'h0;
			frame <= '0;
		end else begin
			frame_valid <= go;
			frame <= go ? f_in : ~frame;
		end
	end
endmodule

// [test/pirl_sva.sv]
`timescale 1ns/1ns
module pirl_sva #(
	parameter int WINDOW_CYCLES = 100,
	parameter int BYTE_W = 24
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic frame_valid,
	input wire pirl_pkg::pirl_frame_t frame,
	input wire logic verdict_valid,
	input wire pirl_pkg::pirl_verdict_t verdict,
	input wire logic [2:0] gap_bytes_include,
	input wire logic [2:0] preamble_include
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_setup_access: assert property (s_setup |=> s_access) else $error("no access answer");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_err_align: assert property ((psel && !penable && paddr[1:0] != 2'h0) |=> pslverr)
		else $error("misaligned accepted");
	a_rd_zero: assert property ((psel && penable && pready && !pwrite) |-> prdata[31:8] == 24'h0)
		else $error("read upper bits set");
	a_verdict_lat: assert property (frame_valid |=> verdict_valid) else $error("verdict missing");
	a_verdict_only: assert property (!frame_valid |=> !verdict_valid) else $error("spurious verdict");
	a_verdict_prio: assert property (frame_valid |=> verdict.prio == $past(frame.prio))
		else $error("verdict priority wrong");
	a_bcast_count: assert property (frame_valid && frame.is_bcast |=> verdict.counted)
		else $error("broadcast not counted");
	a_free_pass: assert property (verdict_valid && !verdict.counted |-> verdict.pass)
		else $error("uncounted frame dropped");
	a_incl_stable: assert property (!(psel && penable && pwrite) |=>
		$stable({gap_bytes_include, preamble_include})) else $error("include bits moved");
endmodule
bind pirl_top pirl_sva #(.WINDOW_CYCLES(WINDOW_CYCLES), .BYTE_W(BYTE_W)) u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .frame_valid(frame_valid), .frame(frame), .verdict_valid(verdict_valid),
	.verdict(verdict), .gap_bytes_include(gap_bytes_include), .preamble_include(preamble_include));

// [test/tb_top.sv]
`timescale 1ns/1ns
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_valid, verdict_valid, go;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	integer seed;
	logic [2:0] port_speed10, gap_bytes_include, preamble_include;
	logic [33:0] re;
	pirl_pkg::pirl_frame_t frame, f_in;
	pirl_pkg::pirl_verdict_t verdict, ve;
	logic [33:0] rq[$];
	pirl_pkg::pirl_verdict_t vq[$];
	int errors, n_compared, k;
	pirl_frame_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .f_in(f_in), .frame_valid(frame_valid),
		.frame(frame));
	pirl_top #(.WINDOW_CYCLES(1000)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frame_valid(frame_valid), .frame(frame), .port_speed10(port_speed10), .verdict_valid(verdict_valid),
		.verdict(verdict), .gap_bytes_include(gap_bytes_include), .preamble_include(preamble_include));
	initial begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end
	task give_verdict;
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
		rq.push_back({w, e});
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		// Request stands until the rising edge that sees pready high
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		if (pready !== 1'h1) begin
			errors++;
			give_verdict;
		end
		{psel, penable} <= 2'h0;
	endtask
	task wr(input logic [5:0] x, input logic [7:0] d);
		apb(1'h1, {x, 2'h0}, {24'h0, d}, 33'h0);
	endtask
	task frm(input logic [1:0] p, pr, input logic [2:0] bmf, input logic [10:0] n, input logic ok, c);
		@(posedge pclk);
		go <= 1'h1;
		f_in <= {p, pr, bmf, n};
		vq.push_back({p, pr, ok, c});
		@(posedge pclk);
		go <= 1'h0;
		repeat (3) @(posedge pclk);
	endtask
	// Results are taken at the rising edge that closes the cycle in which they stand
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			re = rq.pop_front();
			if (re[33]) `CHK("wr_err", re[32], pslverr)
			else `CHK("read", re[32:0], {pslverr, prdata})
		end
		if (verdict_valid === 1'h1) begin
			ve = vq.pop_front();
			`CHK("verdict", ve, verdict)
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		give_verdict;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, go, f_in} = '0;
		{errors, n_compared, presetn} = '0;
		seed = 32'h1F29;
		port_speed10 = 3'h4;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 9; i++)
			apb(1'h0, {pirl_pkg::IDX_P1_CFG + 6'(16 * (i / 3) + i % 3), 2'h0}, 32'h0, 33'h0);
		apb(1'h0, 8'h00, 32'h0, {1'h1, 32'h0});
		apb(1'h0, 8'h59, 32'h0, {1'h1, 32'h0});
		apb(1'h1, 8'h00, 32'hFF, {1'h1, 32'h0});
		rnd = $random(seed);
		apb(1'h1, {pirl_pkg::IDX_P1_RHI, 2'h0}, rnd, 33'h0);
		apb(1'h0, {pirl_pkg::IDX_P1_RHI, 2'h0}, 32'h0, {25'h0, rnd[7:0]});
		wr(pirl_pkg::IDX_P1_RLO, 8'h21);
		wr(pirl_pkg::IDX_P1_RHI, 8'h01);
		wr(pirl_pkg::IDX_P2_CFG, 8'h0D);
		wr(pirl_pkg::IDX_P2_RHI, 8'h21);
		wr(pirl_pkg::IDX_P3_CFG, 8'h02);
		wr(pirl_pkg::IDX_P3_RLO, 8'h91);
		`CHK("gap", 3'h4, gap_bytes_include)
		`CHK("pre", 3'h2, preamble_include)
		frm(0, 0, 0, 8, 1, 1);
		frm(0, 0, 0, 1, 0, 1);
		frm(0, 1, 0, 16, 1, 1);
		frm(0, 1, 0, 1, 0, 1);
		wr(pirl_pkg::IDX_P1_CFG, 8'h04);
		frm(0, 2, 1, 8, 1, 1);
		frm(0, 2, 0, 5, 1, 0);
		wr(pirl_pkg::IDX_P1_CFG, 8'h08);
		frm(0, 2, 1, 1, 1, 0);
		frm(0, 2, 2, 1, 0, 1);
		frm(1, 2, 4, 1, 0, 1);
		frm(1, 2, 2, 1000, 1, 0);
		frm(1, 3, 4, 8, 1, 1);
		frm(1, 3, 4, 1, 0, 1);
		frm(2, 1, 0, 2000, 1, 1);
		frm(2, 0, 0, 1, 0, 1);
		frm(2, 2, 0, 2000, 1, 1);
		// Next window must refill the spent priority 0 budget
		repeat (1000) @(posedge pclk);
		// Port 1 now counts broadcast and multicast only, so send a broadcast
		frm(0, 0, 4, 8, 1, 1);
		// Discards so far: port 1 three, port 2 two, port 3 one
		apb(1'h0, {pirl_pkg::IDX_DROP_P1, 2'h0}, 32'h0, 33'h0_0000_0003);
		apb(1'h0, {pirl_pkg::IDX_DROP_P2, 2'h0}, 32'h0, 33'h0_0000_0002);
		apb(1'h0, {pirl_pkg::IDX_DROP_P3, 2'h0}, 32'h0, 33'h0_0000_0001);
		apb(1'h1, {pirl_pkg::IDX_DROP_P1, 2'h0}, 32'h0, 33'h0);
		apb(1'h0, {pirl_pkg::IDX_DROP_P1, 2'h0}, 32'h0, 33'h0);
		repeat (5) @(posedge pclk);
		`CHK("queues", 0, rq.size() + vq.size())
		give_verdict;
	end
endmodule
